// file: dv/bus_responder.sv
// Purpose: Memory and peripheral model answering the sequencer's bus.
// Assumes: One cycle at a time, cycles back to back while bus_req holds.
// Notes: extra adds wait clocks to every cycle to stretch the operation.
`timescale 1ns/1ns
`default_nettype none
module bus_responder
import cpu_timing_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] extra,
  input wire logic clr,
  input wire logic bus_req,
  input wire cpu_timing_pkg::bus_kind_t bus_kind,
  output logic bus_ack,
  output logic [7:0] rd_cnt,
  output logic [7:0] pf_cnt,
  output logic [7:0] wr_cnt
);
  import cpu_timing_pkg::*;
  logic [3:0] age;
  logic [3:0] need;
  // two-clock answer
  // Acknowledge sits in the last clock; an acknowledge cycle needs three.
  assign need = ((bus_kind == KIND_IACK) ? 4'h2 : 4'h1) + {2'h0, extra};
  assign bus_ack = bus_req && (age >= need);
  // Clocks spent in the current cycle; restarts after each answer.
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !bus_req || bus_ack)
      age <= 4'h0;
    else
      age <= age + 4'h1;
  end
  // Count finished cycles by kind so the bench can check the mix.
  always_ff @(posedge mclk)
  begin
    if (!rst_n || clr)
    begin
      rd_cnt <= 8'h00;
      pf_cnt <= 8'h00;
      wr_cnt <= 8'h00;
    end
    else if (bus_ack)
    begin
      if (bus_kind == KIND_PREFETCH)
        pf_cnt <= pf_cnt + 8'h01;
      else if (bus_kind == KIND_WRITE)
        wr_cnt <= wr_cnt + 8'h01;
      else
        rd_cnt <= rd_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: dv/exception_sequencer_assertions.sv
// Purpose: Port level timing checks on the exception sequencer.
// Assumes: Totals are judged only when timing_met reports prompt acks.
// Notes: Attached to every sequencer by bind.
`timescale 1ns/1ns
`default_nettype none
module exception_sequencer_checker
import cpu_timing_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic op_start,
  input wire cpu_timing_pkg::op_t op_code,
  input wire logic busy,
  input wire logic op_done,
  input wire logic [7:0] op_clocks,
  input wire logic timing_met,
  input wire logic bus_req,
  input wire cpu_timing_pkg::bus_kind_t bus_kind,
  input wire logic bus_write,
  input wire logic save_phase
);
  import cpu_timing_pkg::*;
  op_t last_op;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Remember the accepted operation; refused starts must not disturb it.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      last_op <= OP_INTERRUPT;
    else if (op_start && !busy)
      last_op <= op_code;
  end
  sequence taken(op_t c);
    op_start && !busy && op_code == c;
  endsequence
  sequence met_done(op_t c);
    op_done && timing_met && last_op == c;
  endsequence
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("done pulse too long");
  a_busy_start: assert property (op_start && !busy |=> busy)
    else $error("start not taken");
  a_idle_bus: assert property (!busy |-> !bus_req)
    else $error("bus cycle outside operation");
  a_write_kind: assert property (
    bus_req |-> bus_write == (bus_kind == KIND_WRITE))
    else $error("write flag disagrees with kind");
  a_save_chk: assert property (
    taken(OP_BOUNDS_CHECK) |=> save_phase[*3])
    else $error("bounds check save step missing");
  a_save_mem: assert property (
    taken(OP_FLINE_MEM) |=> save_phase[*3])
    else $error("coprocessor save step missing");
  a_iack_soon: assert property (
    taken(OP_INTERRUPT) |-> ##[1:30] (bus_req && bus_kind == KIND_IACK))
    else $error("no interrupt acknowledge cycle");
  a_int_total: assert property (
    met_done(OP_INTERRUPT) |-> op_clocks == 8'h1E)
    else $error("interrupt total wrong");
  a_freg_total: assert property (
    met_done(OP_FLINE_REG) |-> op_clocks == 8'h1F)
    else $error("coprocessor register total wrong");
  a_bus_error_bound: assert property (
    met_done(OP_BUS_ERROR_INSTR) |-> op_clocks < 8'h3A)
    else $error("bus error entry too long");
  a_ret4_total: assert property (
    met_done(OP_RET_BUS_ERROR4) |-> op_clocks == 8'h42)
    else $error("four word return total wrong");
  a_ret6_total: assert property (
    met_done(OP_RET_BUS_ERROR6) |-> op_clocks == 8'h46)
    else $error("six word return total wrong");
endmodule
bind exception_sequencer exception_sequencer_checker chk (.mclk(mclk),
  .rst_n(rst_n), .op_start(op_start), .op_code(op_code), .busy(busy),
  .op_done(op_done), .op_clocks(op_clocks), .timing_met(timing_met),
  .bus_req(bus_req), .bus_kind(bus_kind), .bus_write(bus_write),
  .save_phase(save_phase));
`default_nettype wire

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the exception sequencer.
// Assumes: 25 MHz mclk, synchronous active low reset.
// Notes: Expected totals and bus mixes are worked out per operation code.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cpu_timing_pkg::*;
  typedef struct {logic [7:0] clk, r, p, w; logic met;} exp_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic op_start = 1'b0;
  op_t op_code = OP_INTERRUPT;
  logic long_operand = 1'b0;
  logic fault_on_write = 1'b0;
  logic [5:0] ea_clocks = 6'h00;
  logic [1:0] extra = 2'h0;
  logic clr = 1'b0;
  logic bus_ack, busy, op_done, timing_met, bus_req, bus_write, save_phase;
  logic [7:0] op_clocks, rd_cnt, pf_cnt, wr_cnt;
  bus_kind_t bus_kind;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0 = 0;
  logic [15:0] lfsr = 16'h7EF1;
  exp_t q[$];
  exception_sequencer uut (.mclk(mclk), .rst_n(rst_n), .op_start(op_start),
    .op_code(op_code), .long_operand(long_operand),
    .fault_on_write(fault_on_write), .ea_clocks(ea_clocks),
    .bus_ack(bus_ack), .busy(busy), .op_done(op_done),
    .op_clocks(op_clocks), .timing_met(timing_met), .bus_req(bus_req),
    .bus_kind(bus_kind), .bus_write(bus_write), .save_phase(save_phase));
  bus_responder mem (.mclk(mclk), .rst_n(rst_n), .extra(extra), .clr(clr),
    .bus_req(bus_req), .bus_kind(bus_kind), .bus_ack(bus_ack),
    .rd_cnt(rd_cnt), .pf_cnt(pf_cnt), .wr_cnt(wr_cnt));
  // Free running clock, 40 ns period.
  always #20 mclk = ~mclk;
  // Next pseudo random state.
  function automatic logic [15:0] next_lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Nominal figures; every wait clock adds one clock per bus cycle.
  function automatic exp_t expect_op(op_t op, logic lg, logic fw,
    logic [5:0] ea, logic [1:0] ex);
    exp_t e;
    case (op)
      OP_INTERRUPT: e = '{8'h1E, 8'h03, 8'h02, 8'h04, 1'b1};
      OP_FLINE_REG: e = '{8'h1F, 8'h02, 8'h03, 8'h04, 1'b1};
      OP_FLINE_MEM: e = '{8'h20 + {2'h0, ea}, 8'h02, 8'h03, 8'h04, 1'b1};
      OP_BOUNDS_CHECK: e = '{8'h15 + {2'h0, ea} + (lg ? 8'h02 : 8'h00),
        8'h01 + {7'h00, lg}, 8'h01, 8'h00, 1'b1};
      OP_BUS_ERROR_INSTR: e = '{8'h39, 8'h02, 8'h02, 8'h0C, 1'b1};
      OP_RET_BUS_ERROR4: e = '{8'h42, 8'h0A, 8'h02, 8'h04, 1'b1};
      OP_RET_BUS_ERROR6: e = '{8'h46, 8'h0C, 8'h02, 8'h06, 1'b1};
      default: e = '{8'h32 + (fw ? 8'h02 : 8'h00), 8'h0C, 8'h0C,
        {7'h00, fw}, 1'b1};
    endcase
    e.clk = e.clk + {6'h00, ex} * (e.r + e.p + e.w);
    e.met = (ex == 2'h0);
    return e;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] want,
    input string what);
    tests_run++;
    if (got !== want)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what,
        got, want);
    end
  endtask
  // One operation; poke tries a second start while busy.
  task automatic run_op(input op_t op, input logic lg, input logic fw,
    input logic [5:0] ea, input logic [1:0] ex, input logic poke);
    int n;
    q.push_back(expect_op(op, lg, fw, ea, ex));
    @(posedge mclk);
    op_start <= 1'b1;
    op_code <= op;
    long_operand <= lg;
    fault_on_write <= fw;
    ea_clocks <= ea;
    extra <= ex;
    clr <= 1'b1;
    @(posedge mclk);
    op_start <= 1'b0;
    clr <= 1'b0;
    if (poke)
    begin
      repeat (4) @(posedge mclk);
      op_start <= 1'b1;
      op_code <= OP_RET_BUS_ERROR6;
      @(posedge mclk);
      op_start <= 1'b0;
    end
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    if (n >= 400)
      cmp(8'h00, 8'h01, "busy stuck");
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Takes the oldest note at each done pulse and checks the result.
  always @(posedge mclk)
  begin : mon
    exp_t e;
    cyc++;
    if (op_start && busy === 1'b0)
      t0 = cyc;
    if (op_done === 1'b1)
    begin
      if (q.size() == 0)
        cmp(8'h01, 8'h00, "unexpected done");
      else
      begin
        e = q.pop_front();
        cmp(op_clocks, e.clk, "total clocks");
        cmp(8'(cyc - t0), e.clk + 8'h01, "done latency");
        cmp({7'h00, timing_met}, {7'h00, e.met}, "timing met");
        cmp(rd_cnt, e.r, "reads");
        cmp(pf_cnt, e.p, "prefetches");
        cmp(wr_cnt, e.w, "writes");
      end
    end
  end
  // Main sequence: every code, boundaries, then random stretched traffic.
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      run_op(op_t'(3'(i)), 1'b0, 1'b0, 6'h00, 2'h0, i == 3);
    run_op(OP_BOUNDS_CHECK, 1'b1, 1'b0, 6'h05, 2'h0, 1'b0);
    run_op(OP_FLINE_MEM, 1'b0, 1'b0, 6'h3F, 2'h0, 1'b0);
    run_op(OP_RET_BUS_ERROR_INSTR, 1'b0, 1'b1, 6'h00, 2'h0, 1'b0);
    for (int i = 0; i < 12; i++)
    begin
      lfsr = next_lfsr(lfsr);
      run_op(op_t'(lfsr[2:0]), lfsr[3], lfsr[4], {3'h0, lfsr[7:5]},
        lfsr[9:8], 1'b0);
    end
    repeat (2) @(posedge mclk);
    cmp(8'(q.size()), 8'h00, "missing done");
    report_and_stop();
  end
  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #800000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: verilog/bus_cycle_unit.sv
// Purpose: Run back-to-back external bus cycles for the sequencer.
// Assumes: Responder raises bus_ack in the last clock of a cycle.
// Notes: A cycle never ends before its minimum length.
`timescale 1ns/1ns
`default_nettype none
module bus_cycle_unit
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic want,
  input wire logic iack_now,
  input wire logic bus_ack,
  output logic bus_req,
  output logic cycle_done
);
  import cpu_timing_pkg::*;

  logic [1:0] cnt;
  logic [1:0] min_clocks;

  assign min_clocks = iack_now ? IACK_CLOCKS : BUS_CLOCKS;
  assign cycle_done = bus_req && bus_ack && (cnt >= min_clocks);

  // Request stays up across cycles, so no clock is lost between them.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bus_req <= 1'b0;
    else if (!bus_req || cycle_done)
      bus_req <= want;
  end

  // Clocks spent in the current cycle; saturates for slow responders.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt <= 2'h1;
    else if (!bus_req || cycle_done)
      cnt <= 2'h1;
    else if (cnt != 2'h3)
      cnt <= cnt + 2'h1;
  end

endmodule
`default_nettype wire

// file: verilog/cpu_timing_pkg.sv
// Purpose: Constants and types for the exception and control timing core.
// Assumes: One 25 MHz clock; responders answer reads and writes in 2 clocks.
// Notes: Totals include every read, prefetch and write of the operation.
package cpu_timing_pkg;

  // ********************************************************
  // Bus and clock
  // ********************************************************
  localparam int CLK_MHZ = 25;
  localparam int BUS_PORT_BITS = 16;
  localparam logic [1:0] BUS_CLOCKS = 2'h2;
  localparam logic [1:0] IACK_CLOCKS = 2'h3;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [2:0] {
    OP_INTERRUPT = 3'h0,
    OP_FLINE_REG = 3'h1,
    OP_FLINE_MEM = 3'h2,
    OP_BOUNDS_CHECK = 3'h3,
    OP_BUS_ERROR_INSTR = 3'h4,
    OP_RET_BUS_ERROR4 = 3'h5,
    OP_RET_BUS_ERROR6 = 3'h6,
    OP_RET_BUS_ERROR_INSTR = 3'h7
  } op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SAVE = 5'h02,
    ST_EA = 5'h04,
    ST_OPER = 5'h08,
    ST_DONE = 5'h10
  } state_t;

  typedef enum logic [1:0] {
    KIND_READ = 2'h0,
    KIND_PREFETCH = 2'h1,
    KIND_WRITE = 2'h2,
    KIND_IACK = 2'h3
  } bus_kind_t;

  // ********************************************************
  // Operation timing: total clocks and read/prefetch/write
  // ********************************************************
  localparam logic [7:0] SAVE_TOTAL = 8'h03;
  localparam logic [4:0] SAVE_PF = 5'h01;
  localparam logic [7:0] INT_TOTAL = 8'h1E;
  localparam logic [4:0] INT_RD = 5'h03;
  localparam logic [4:0] INT_PF = 5'h02;
  localparam logic [4:0] INT_WR = 5'h04;
  localparam logic [7:0] FREG_TOTAL = 8'h1F;
  localparam logic [4:0] FREG_RD = 5'h02;
  localparam logic [4:0] FREG_PF = 5'h03;
  localparam logic [4:0] FREG_WR = 5'h04;
  localparam logic [7:0] FMEM_TOTAL = 8'h1D;
  localparam logic [4:0] FMEM_RD = 5'h02;
  localparam logic [4:0] FMEM_PF = 5'h02;
  localparam logic [4:0] FMEM_WR = 5'h04;
  localparam logic [7:0] CHK_TOTAL = 8'h12;
  localparam logic [4:0] CHK_RD = 5'h01;
  localparam logic [7:0] BUS_ERROR_TOTAL = 8'h39;
  localparam logic [4:0] BUS_ERROR_RD = 5'h02;
  localparam logic [4:0] BUS_ERROR_PF = 5'h02;
  localparam logic [4:0] BUS_ERROR_WR = 5'h0C;
  localparam logic [7:0] RB4_TOTAL = 8'h42;
  localparam logic [4:0] RB4_RD = 5'h0A;
  localparam logic [4:0] RB4_PF = 5'h02;
  localparam logic [4:0] RB4_WR = 5'h04;
  localparam logic [7:0] RB6_TOTAL = 8'h46;
  localparam logic [4:0] RB6_RD = 5'h0C;
  localparam logic [4:0] RB6_PF = 5'h02;
  localparam logic [4:0] RB6_WR = 5'h06;
  localparam logic [7:0] RBI_TOTAL = 8'h32;
  localparam logic [4:0] RBI_RD = 5'h0C;
  localparam logic [4:0] RBI_PF = 5'h0C;
  localparam logic [4:0] RBI_WR = 5'h01;
  localparam logic [7:0] LONG_EXTRA = 8'h02;
  localparam logic [7:0] RERUN_EXTRA = 8'h02;

endpackage

// file: verilog/exception_sequencer.sv
// Purpose: Sequence exception and control operations to their clock counts.
// Assumes: Inputs synchronous to mclk; one operation at a time.
// Notes: A slow responder stretches the operation and clears timing_met.
`timescale 1ns/1ns
`default_nettype none
module exception_sequencer
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic op_start,
  input wire cpu_timing_pkg::op_t op_code,
  input wire logic long_operand,
  input wire logic fault_on_write,
  input wire logic [5:0] ea_clocks,
  input wire logic bus_ack,
  output logic busy,
  output logic op_done,
  output logic [7:0] op_clocks,
  output logic timing_met,
  output logic bus_req,
  output var cpu_timing_pkg::bus_kind_t bus_kind,
  output logic bus_write,
  output logic save_phase
);
  import cpu_timing_pkg::*;

  // ********************************************************
  // Declarations
  // ********************************************************
  state_t state;
  state_t next_state;
  op_t held_op;
  op_t tbl_op;
  logic held_long;
  logic held_rerun;
  logic [5:0] held_ea;
  logic in_bus;
  logic [7:0] icnt;
  logic [4:0] bleft;
  logic [4:0] bidx;
  logic [4:0] phase_rd;
  logic [4:0] phase_pf;
  logic iack_op;
  logic [7:0] elapsed;
  logic [7:0] nominal;
  logic tbl_save;
  logic [7:0] tbl_total;
  logic [4:0] tbl_rd;
  logic [4:0] tbl_pf;
  logic [4:0] tbl_wr;
  logic [5:0] tbl_bus;
  logic [7:0] ld_icnt;
  logic ld;
  logic ld_ea;
  logic want;
  logic cyc_done;
  logic phase_end;
  logic needs_save;
  bus_kind_t next_kind;
  logic [4:0] sel_rd;
  logic [4:0] sel_pf;
  logic [4:0] sel_idx;
  logic sel_iack;

  // ********************************************************
  // Phase table and bus engine
  // ********************************************************
  assign tbl_op = state[0] ? op_code : held_op;
  assign needs_save = (op_code == OP_BOUNDS_CHECK) ||
                      (op_code == OP_FLINE_MEM);
  assign tbl_save = state[0] && needs_save;

  op_timing u_timing
  (
    .op(tbl_op),
    .save_step(tbl_save),
    .long_operand(state[0] ? long_operand : held_long),
    .write_rerun(state[0] ? fault_on_write : held_rerun),
    .total(tbl_total),
    .reads(tbl_rd),
    .prefetches(tbl_pf),
    .writes(tbl_wr)
  );

  bus_cycle_unit u_bus
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .want(want),
    .iack_now(bus_kind == KIND_IACK),
    .bus_ack(bus_ack),
    .bus_req(bus_req),
    .cycle_done(cyc_done)
  );

  assign tbl_bus = {1'b0, tbl_rd} + {1'b0, tbl_pf} + {1'b0, tbl_wr};
  // The acknowledge cycle is one clock longer than a plain read.
  assign sel_iack = (tbl_op == OP_INTERRUPT) && !tbl_save;
  assign ld_icnt = tbl_total - {1'b0, tbl_bus, 1'b0} -
                   {7'h00, sel_iack};

  // ********************************************************
  // Sequencing
  // ********************************************************
  // A phase ends on its last internal clock or its last bus cycle.
  always_comb
  begin
    phase_end = in_bus ? (cyc_done && bleft == 5'h01) :
                (icnt == 8'h01 && bleft == 5'h00);
    want = in_bus ? (bleft > 5'h01) :
           (!state[0] && icnt == 8'h01 && bleft != 5'h00);
    ld = 1'b0;
    ld_ea = 1'b0;
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (op_start)
        begin
          ld = 1'b1;
          next_state = needs_save ? ST_SAVE : ST_OPER;
        end
      end
      ST_SAVE:
      begin
        if (phase_end && held_ea != 6'h00)
        begin
          ld_ea = 1'b1;
          next_state = ST_EA;
        end
        else if (phase_end)
        begin
          ld = 1'b1;
          next_state = ST_OPER;
        end
      end
      ST_EA:
      begin
        if (phase_end)
        begin
          ld = 1'b1;
          next_state = ST_OPER;
        end
      end
      ST_OPER:
      begin
        if (phase_end)
          next_state = ST_DONE;
      end
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Operation options are held for the whole operation.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      held_op <= OP_INTERRUPT;
      held_long <= 1'b0;
      held_rerun <= 1'b0;
      held_ea <= 6'h00;
    end
    else if (state[0] && op_start)
    begin
      held_op <= op_code;
      held_long <= long_operand;
      held_rerun <= fault_on_write;
      held_ea <= ea_clocks;
    end
  end

  // Internal clocks come first, then reads, prefetches and writes.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      in_bus <= 1'b0;
      icnt <= 8'h00;
      bleft <= 5'h00;
      bidx <= 5'h00;
      phase_rd <= 5'h00;
      phase_pf <= 5'h00;
      iack_op <= 1'b0;
    end
    else if (ld)
    begin
      in_bus <= 1'b0;
      icnt <= ld_icnt;
      bleft <= tbl_bus[4:0];
      bidx <= 5'h00;
      phase_rd <= tbl_rd;
      phase_pf <= tbl_pf;
      iack_op <= sel_iack;
    end
    else if (ld_ea)
    begin
      in_bus <= 1'b0;
      icnt <= {2'h0, held_ea};
      bleft <= 5'h00;
    end
    else if (!in_bus && icnt != 8'h00)
    begin
      icnt <= icnt - 8'h01;
      in_bus <= (icnt == 8'h01) && (bleft != 5'h00);
    end
    else if (in_bus && cyc_done)
    begin
      bleft <= bleft - 5'h01;
      bidx <= bidx + 5'h01;
      in_bus <= (bleft != 5'h01);
    end
  end

  // ********************************************************
  // Bus cycle kind
  // ********************************************************
  // Kind of the next cycle is prepared before its request rises.
  always_comb
  begin
    sel_rd = ld ? tbl_rd : phase_rd;
    sel_pf = ld ? tbl_pf : phase_pf;
    sel_idx = ld ? 5'h00 : bidx + 5'h01;
    if (sel_idx < sel_rd)
    begin
      if (sel_idx == 5'h00 && (ld ? sel_iack : iack_op))
        next_kind = KIND_IACK;
      else
        next_kind = KIND_READ;
    end
    else if (sel_idx < sel_rd + sel_pf)
      next_kind = KIND_PREFETCH;
    else
      next_kind = KIND_WRITE;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bus_kind <= KIND_READ;
      bus_write <= 1'b0;
    end
    else if (ld || cyc_done)
    begin
      bus_kind <= next_kind;
      bus_write <= (next_kind == KIND_WRITE);
    end
  end

  // ********************************************************
  // Elapsed clocks and result
  // ********************************************************
  // Nominal sums phase totals; a stall makes elapsed exceed it.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      elapsed <= 8'h00;
      nominal <= 8'h00;
    end
    else if (state[0])
    begin
      elapsed <= 8'h00;
      nominal <= op_start ? tbl_total : 8'h00;
    end
    else if (!state[4])
    begin
      elapsed <= (elapsed == 8'hFF) ? elapsed : elapsed + 8'h01;
      if (ld)
        nominal <= nominal + tbl_total;
      else if (ld_ea)
        nominal <= nominal + {2'h0, held_ea};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      op_done <= 1'b0;
      op_clocks <= 8'h00;
      timing_met <= 1'b0;
    end
    else
    begin
      op_done <= state[3] && phase_end;
      if (state[3] && phase_end)
      begin
        op_clocks <= elapsed + 8'h01;
        timing_met <= (elapsed + 8'h01) == nominal;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      save_phase <= 1'b0;
    end
    else
    begin
      busy <= !next_state[0];
      save_phase <= next_state[1] && (BUS_PORT_BITS == 16);
    end
  end

endmodule
`default_nettype wire

// file: verilog/op_timing.sv
// Purpose: Look up total clocks and bus cycle mix for one phase.
// Assumes: Caller latches the result when the phase starts.
// Notes: Purely combinational.
`timescale 1ns/1ns
`default_nettype none
module op_timing
(
  input wire cpu_timing_pkg::op_t op,
  input wire logic save_step,
  input wire logic long_operand,
  input wire logic write_rerun,
  output logic [7:0] total,
  output logic [4:0] reads,
  output logic [4:0] prefetches,
  output logic [4:0] writes
);
  import cpu_timing_pkg::*;

  // Phase table; every total already counts its bus cycles.
  always_comb
  begin
    total = SAVE_TOTAL;
    reads = 5'h00;
    prefetches = SAVE_PF;
    writes = 5'h00;
    if (!save_step)
    begin
      case (op)
        OP_INTERRUPT:
        begin
          total = INT_TOTAL;
          reads = INT_RD;
          prefetches = INT_PF;
          writes = INT_WR;
        end
        OP_FLINE_REG:
        begin
          total = FREG_TOTAL;
          reads = FREG_RD;
          prefetches = FREG_PF;
          writes = FREG_WR;
        end
        OP_FLINE_MEM:
        begin
          total = FMEM_TOTAL;
          reads = FMEM_RD;
          prefetches = FMEM_PF;
          writes = FMEM_WR;
        end
        OP_BOUNDS_CHECK:
        begin
          total = long_operand ? CHK_TOTAL + LONG_EXTRA : CHK_TOTAL;
          reads = long_operand ? CHK_RD + 5'h01 : CHK_RD;
          prefetches = 5'h00;
          writes = 5'h00;
        end
        OP_BUS_ERROR_INSTR:
        begin
          total = BUS_ERROR_TOTAL;
          reads = BUS_ERROR_RD;
          prefetches = BUS_ERROR_PF;
          writes = BUS_ERROR_WR;
        end
        OP_RET_BUS_ERROR4:
        begin
          total = RB4_TOTAL;
          reads = RB4_RD;
          prefetches = RB4_PF;
          writes = RB4_WR;
        end
        OP_RET_BUS_ERROR6:
        begin
          total = RB6_TOTAL;
          reads = RB6_RD;
          prefetches = RB6_PF;
          writes = RB6_WR;
        end
        default:
        begin
          total = write_rerun ? RBI_TOTAL + RERUN_EXTRA : RBI_TOTAL;
          reads = RBI_RD;
          prefetches = RBI_PF;
          writes = write_rerun ? RBI_WR : 5'h00;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: verilog/unused_placeholder_none.sv
// Purpose: None.
// Assumes: None.
// Notes: Intentionally empty.
